// >>> include/psc_pkg.sv
// psc_pkg: constants, types and helpers of the synthesizer serial control block
package psc_pkg;
	localparam int unsigned WORD_W     = 8;
	localparam int unsigned DATA_W     = 6;
	localparam int unsigned CNT_W      = 4;
	localparam int unsigned PIN_N      = 7;
	localparam logic [3:0]  BITS_WORD  = 4'h8;
	localparam logic [3:0]  BITS_OVER  = 4'h9;
	localparam logic [3:0]  BITS_ZERO  = 4'h0;
	localparam logic [5:0]  REG_RST    = 6'h00;
	localparam logic [7:0]  PC_RST     = 8'h00;
	// address codes as sent, first address bit on the left
	localparam logic [1:0]  ADR_TEST   = 2'h0;
	localparam logic [1:0]  ADR_CTRL   = 2'h1;
	localparam logic [1:0]  ADR_LOW    = 2'h2;
	localparam logic [1:0]  ADR_SWL    = 2'h3;
	// field positions inside the six data bits
	localparam int unsigned TEST_MSB   = 5;
	localparam int unsigned TEST_LSB   = 3;
	localparam int unsigned SOUT_BIT   = 2;
	localparam int unsigned CUR2_BIT   = 1;
	localparam int unsigned STEP_BIT   = 0;
	localparam int unsigned PCHI_MSB   = 5;
	localparam int unsigned PCHI_LSB   = 4;
	localparam int unsigned FILT_BIT   = 3;
	localparam int unsigned CUR1_BIT   = 2;
	localparam int unsigned SWD_BIT    = 1;
	localparam int unsigned BAND_BIT   = 0;
	// test codes written as {bit_a, bit_b, bit_c}
	localparam logic [2:0]  TC_NORMAL  = 3'h0;
	localparam logic [2:0]  TC_REF_OUT = 3'h4;
	localparam logic [2:0]  TC_PHI_OUT = 3'h2;
	localparam logic [2:0]  TC_SYN_OUT = 3'h6;
	localparam logic [2:0]  TC_PHI_IN  = 3'h1;
	// pin vector positions
	localparam int unsigned PIN_SCLK   = 0;
	localparam int unsigned PIN_SDATA  = 1;
	localparam int unsigned PIN_SEN    = 2;
	localparam int unsigned PIN_OSC    = 3;
	localparam int unsigned PIN_EXTREF = 4;
	localparam int unsigned PIN_FSYN   = 5;
	localparam int unsigned PIN_EXTPHI = 6;

	typedef enum logic [1:0] {MODE_STANDBY, MODE_FM, MODE_AM_SWALLOW, MODE_AM_DIRECT}
		psc_mode_type;

	typedef struct packed {
		logic sclk;
		logic sdata;
		logic sen;
	} psc_bus_type;

	typedef struct packed {
		logic       up;
		logic       dn;
		logic [1:0] cur;
	} psc_pump_type;

	// rising edge of a sampled level
	function automatic logic psc_rise(input logic cur, input logic prev);
		return cur & ~prev;
	endfunction

	// falling edge of a sampled level
	function automatic logic psc_fall(input logic cur, input logic prev);
		return ~cur & prev;
	endfunction
endpackage

// >>> rtl/psc_phase_cmp.sv
// psc_phase_cmp: three-state phase comparator driving pump up/down requests
`timescale 1ns/100ps
module psc_phase_cmp
(
	input  wire logic i_ref_clk,  // core clock
	input  wire logic i_rst_n,    // async reset, active low
	input  wire logic i_enable,   // comparator running
	input  wire logic i_ref,      // synchronised reference level
	input  wire logic i_syn,      // synchronised divided clock level
	output logic      o_up,       // pump up request
	output logic      o_dn        // pump down request
);
	import psc_pkg::*;

	logic ref_prev_r;
	logic syn_prev_r;
	logic up_r;
	logic up_nxt;
	logic dn_r;
	logic dn_nxt;
	logic ref_e;
	logic syn_e;

	assign ref_e = psc_rise(i_ref, ref_prev_r);
	assign syn_e = psc_rise(i_syn, syn_prev_r);

	// lead/lag state: reference first pumps up, divided clock first pumps down
	always_comb
	begin
		up_nxt = up_r;
		dn_nxt = dn_r;
		if (!i_enable || (ref_e && syn_e))
		begin
			up_nxt = 1'b0;
			dn_nxt = 1'b0;
		end
		else if (ref_e)
		begin
			up_nxt = ~dn_r;
			dn_nxt = 1'b0;
		end
		else if (syn_e)
		begin
			dn_nxt = ~up_r;
			up_nxt = 1'b0;
		end
	end

	// register comparator state
	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			ref_prev_r <= 1'b0;
			syn_prev_r <= 1'b0;
			up_r       <= 1'b0;
			dn_r       <= 1'b0;
		end
		else
		begin
			ref_prev_r <= i_ref;
			syn_prev_r <= i_syn;
			up_r       <= up_nxt;
			dn_r       <= dn_nxt;
		end
	end

	assign o_up = up_r;
	assign o_dn = dn_r;

	////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_n);

	property p_excl;
		!(up_r && dn_r);
	endproperty
	a_excl: assert property (p_excl) else $error("pump up and down together");

	property p_coincide;
		(ref_e && syn_e) |=> (!up_r && !dn_r);
	endproperty
	a_coincide: assert property (p_coincide) else $error("coincident edges pumped");

	property p_lead;
		(i_enable && ref_e && !syn_e && !dn_r) |=> up_r;
	endproperty
	a_lead: assert property (p_lead) else $error("reference lead did not pump up");

	property p_lag;
		(i_enable && syn_e && !ref_e && up_r) |=> !up_r && !dn_r;
	endproperty
	a_lag: assert property (p_lag) else $error("lag edge did not end up pulse");

	c_up: cover property (up_r ##[1:20] !up_r);
endmodule

// >>> rtl/psc_serial_ctrl.sv
// psc_serial_ctrl: serial word receiver, control registers and test routing
`timescale 1ns/100ps
module psc_serial_ctrl
(
	input  wire logic                   i_ref_clk,      // core clock, 250 MHz
	input  wire logic                   i_rst_n,        // async reset, active low
	input  wire psc_pkg::psc_bus_type   i_bus,          // serial clock, data, enable pins
	input  wire logic                   i_osc_ref,      // reference from internal divider
	input  wire logic                   i_ext_ref,      // oscillator pin as reference input
	input  wire logic                   i_fsyn,         // divided synthesized clock
	input  wire logic                   i_test_in,      // test pin input level
	output psc_pkg::psc_pump_type       o_pump,         // pump up/down and current select
	output logic                        o_filter_input_sel, // 0 first pin, 1 second pin
	output logic                        o_test_out,     // test pin drive level
	output logic                        o_test_oe,      // test pin output enable
	output logic                        o_osc_ext_ref,  // oscillator pin used as ref input
	output psc_pkg::psc_mode_type       o_mode,         // decoded operating mode
	output logic [7:0]                  o_prog_counter_bits, // live programmable counter
	output logic [5:0]                  o_swallow_count_bits, // swallow counter
	output logic                        o_ref_step_sel  // reference step select
);
	import psc_pkg::*;

	typedef enum logic {S_IDLE, S_SHIFT} psc_rx_type;

	logic [PIN_N-1:0]  sync1_r;
	logic [PIN_N-1:0]  sync2_r;
	logic [PIN_N-1:0]  sync3_r;
	logic              sclk_rise;
	logic              sen_rise;
	logic              sen_fall;
	psc_rx_type        state_r;
	psc_rx_type        state_nxt;
	logic [WORD_W-1:0] shift_r;
	logic [WORD_W-1:0] shift_nxt;
	logic [CNT_W-1:0]  cnt_r;
	logic [CNT_W-1:0]  cnt_nxt;
	logic              wr_r;
	logic              wr_nxt;
	logic [DATA_W-1:0] test_r;
	logic [DATA_W-1:0] test_nxt;
	logic [DATA_W-1:0] ctrl_r;
	logic [DATA_W-1:0] ctrl_nxt;
	logic [DATA_W-1:0] low_r;
	logic [DATA_W-1:0] low_nxt;
	logic [DATA_W-1:0] swl_r;
	logic [DATA_W-1:0] swl_nxt;
	logic [7:0]        pc_r;
	logic [7:0]        pc_nxt;
	logic [2:0]        tcode;
	logic              ext_ref_mode;
	psc_mode_type      mode;
	logic              cmp_en;
	logic              cmp_up;
	logic              cmp_dn;
	psc_pump_type      pump_r;
	psc_pump_type      pump_nxt;
	logic              filt_r;
	logic              tout_r;
	logic              tout_nxt;
	logic              toe_r;
	logic              toe_nxt;
	logic              extr_r;
	psc_mode_type      mode_r;

	////////////////////////////////////////////////////////////////////////////
	// pin synchronisers; edges only from the second and third stages
	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			sync1_r <= '0;
			sync2_r <= '0;
			sync3_r <= '0;
		end
		else
		begin
			sync1_r <= {i_test_in, i_fsyn, i_ext_ref, i_osc_ref, i_bus.sen, i_bus.sdata,
				i_bus.sclk};
			sync2_r <= sync1_r;
			sync3_r <= sync2_r;
		end
	end

	assign sclk_rise = psc_rise(sync2_r[PIN_SCLK], sync3_r[PIN_SCLK]);
	assign sen_rise  = psc_rise(sync2_r[PIN_SEN], sync3_r[PIN_SEN]);
	assign sen_fall  = psc_fall(sync2_r[PIN_SEN], sync3_r[PIN_SEN]);

	////////////////////////////////////////////////////////////////////////////
	// receiver: shift while enable high, check bit count when enable drops
	always_comb
	begin
		state_nxt = state_r;
		shift_nxt = shift_r;
		cnt_nxt   = cnt_r;
		wr_nxt    = 1'b0;
		unique case (state_r)
			S_IDLE:
			begin
				if (sen_rise)
				begin
					cnt_nxt   = BITS_ZERO;
					state_nxt = S_SHIFT;
				end
			end
			S_SHIFT:
			begin
				if (sen_fall)
				begin
					wr_nxt    = (cnt_r == BITS_WORD);
					state_nxt = S_IDLE;
				end
				else if (sclk_rise)
				begin
					shift_nxt = {shift_r[WORD_W-2:0], sync2_r[PIN_SDATA]};
					cnt_nxt   = (cnt_r == BITS_OVER) ? cnt_r : cnt_r + 4'h1;
				end
			end
		endcase
	end

	// register receiver state
	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			state_r <= S_IDLE;
			shift_r <= '0;
			cnt_r   <= BITS_ZERO;
			wr_r    <= 1'b0;
		end
		else
		begin
			state_r <= state_nxt;
			shift_r <= shift_nxt;
			cnt_r   <= cnt_nxt;
			wr_r    <= wr_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// register file: address bits pick one of four six-bit registers
	always_comb
	begin
		test_nxt = test_r;
		ctrl_nxt = ctrl_r;
		low_nxt  = low_r;
		swl_nxt  = swl_r;
		pc_nxt   = pc_r;
		if (wr_r)
		begin
			unique case (shift_r[WORD_W-1:DATA_W])
				ADR_TEST: test_nxt = shift_r[DATA_W-1:0];
				ADR_CTRL: ctrl_nxt = shift_r[DATA_W-1:0];
				ADR_LOW:  low_nxt  = shift_r[DATA_W-1:0];
				ADR_SWL:
				begin
					swl_nxt = shift_r[DATA_W-1:0];
					pc_nxt  = {ctrl_r[PCHI_MSB:PCHI_LSB], low_r};
				end
			endcase
		end
	end

	// register the control words; reset gives all zero and standby
	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			test_r <= REG_RST;
			ctrl_r <= REG_RST;
			low_r  <= REG_RST;
			swl_r  <= REG_RST;
			pc_r   <= PC_RST;
		end
		else
		begin
			test_r <= test_nxt;
			ctrl_r <= ctrl_nxt;
			low_r  <= low_nxt;
			swl_r  <= swl_nxt;
			pc_r   <= pc_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// mode decode and test code routing
	assign tcode        = test_r[TEST_MSB:TEST_LSB];
	assign ext_ref_mode = (tcode == TC_PHI_OUT) || (tcode == TC_SYN_OUT);

	always_comb
	begin
		unique case ({ctrl_r[SWD_BIT], ctrl_r[BAND_BIT]})
			2'h0:    mode = MODE_STANDBY;
			2'h2:    mode = MODE_FM;
			2'h1:    mode = MODE_AM_SWALLOW;
			2'h3:    mode = MODE_AM_DIRECT;
		endcase
	end

	assign cmp_en = (mode != MODE_STANDBY) && (tcode != TC_PHI_IN);

	psc_phase_cmp u_cmp
	(
		.i_ref_clk (i_ref_clk),
		.i_rst_n   (i_rst_n),
		.i_enable  (cmp_en),
		.i_ref     (ext_ref_mode ? sync2_r[PIN_EXTREF] : sync2_r[PIN_OSC]),
		.i_syn     (sync2_r[PIN_FSYN]),
		.o_up      (cmp_up),
		.o_dn      (cmp_dn)
	);

	// pump drive and test pin selection
	always_comb
	begin
		pump_nxt.cur = {test_r[CUR2_BIT], ctrl_r[CUR1_BIT]};
		pump_nxt.up  = cmp_up;
		pump_nxt.dn  = cmp_dn;
		tout_nxt     = test_r[SOUT_BIT];
		toe_nxt      = 1'b1;
		unique case (tcode)
			TC_REF_OUT: tout_nxt = ext_ref_mode ? sync2_r[PIN_EXTREF] : sync2_r[PIN_OSC];
			TC_PHI_OUT: tout_nxt = cmp_up | cmp_dn;
			TC_SYN_OUT: tout_nxt = sync2_r[PIN_FSYN];
			TC_PHI_IN:
			begin
				toe_nxt     = 1'b0;
				tout_nxt    = 1'b0;
				pump_nxt.up = (mode != MODE_STANDBY) && sync2_r[PIN_EXTPHI];
				pump_nxt.dn = (mode != MODE_STANDBY) && !sync2_r[PIN_EXTPHI];
			end
			default: tout_nxt = test_r[SOUT_BIT];
		endcase
	end

	// output registers
	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			pump_r <= '0;
			filt_r <= 1'b0;
			tout_r <= 1'b0;
			toe_r  <= 1'b1;
			extr_r <= 1'b0;
			mode_r <= MODE_STANDBY;
		end
		else
		begin
			pump_r <= pump_nxt;
			filt_r <= ctrl_r[FILT_BIT];
			tout_r <= tout_nxt;
			toe_r  <= toe_nxt;
			extr_r <= ext_ref_mode;
			mode_r <= mode;
		end
	end

	assign o_pump               = pump_r;
	assign o_filter_input_sel   = filt_r;
	assign o_test_out           = tout_r;
	assign o_test_oe            = toe_r;
	assign o_osc_ext_ref        = extr_r;
	assign o_mode               = mode_r;
	assign o_prog_counter_bits  = pc_r;
	assign o_swallow_count_bits = swl_r;
	assign o_ref_step_sel       = test_r[STEP_BIT];

	////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_n);

	property p_fmt;
		(state_r == S_SHIFT && sen_fall && cnt_r != BITS_WORD) |=> !wr_r;
	endproperty
	a_fmt: assert property (p_fmt) else $error("malformed word accepted");

	property p_hold;
		!wr_r |=> $stable(test_r) && $stable(ctrl_r) && $stable(low_r) && $stable(swl_r);
	endproperty
	a_hold: assert property (p_hold) else $error("register changed without a word");

	property p_swl;
		(wr_r && shift_r[WORD_W-1:DATA_W] == ADR_SWL) |=>
			o_swallow_count_bits == $past(shift_r[DATA_W-1:0]);
	endproperty
	a_swl: assert property (p_swl) else $error("swallow word not stored");

	property p_pc;
		!(wr_r && shift_r[WORD_W-1:DATA_W] == ADR_SWL) |=> $stable(o_prog_counter_bits);
	endproperty
	a_pc: assert property (p_pc) else $error("live counter changed early");

	property p_cur;
		##1 o_pump.cur == $past({test_r[CUR2_BIT], ctrl_r[CUR1_BIT]});
	endproperty
	a_cur: assert property (p_cur) else $error("pump current select wrong");

	property p_filt;
		$changed(ctrl_r[FILT_BIT]) |=> o_filter_input_sel == $past(ctrl_r[FILT_BIT]);
	endproperty
	a_filt: assert property (p_filt) else $error("filter input select wrong");

	property p_sout;
		(tcode == TC_NORMAL) |=> (o_test_oe && o_test_out == $past(test_r[SOUT_BIT]));
	endproperty
	a_sout: assert property (p_sout) else $error("switch level not on test pin");

	property p_extref;
		ext_ref_mode |=> o_osc_ext_ref;
	endproperty
	a_extref: assert property (p_extref) else $error("oscillator pin not reference input");

	property p_stby;
		(mode == MODE_STANDBY) [*3] |=> !o_pump.up && !o_pump.dn;
	endproperty
	a_stby: assert property (p_stby) else $error("pump active in standby");

	c_word: cover property (wr_r && shift_r[WORD_W-1:DATA_W] == ADR_SWL);
	c_bad:  cover property (state_r == S_SHIFT && sen_fall && cnt_r != BITS_WORD);
	c_fm:   cover property (mode_r == MODE_FM ##[1:50] o_pump.up);
endmodule

// >>> verification/psc_host_model.sv
// psc_host_model: host side of the three-wire serial bus
`timescale 1ns/100ps
module psc_host_model
(
	input  wire logic            i_clk, // core clock used for pacing
	output psc_pkg::psc_bus_type o_bus  // serial clock, data, enable
);
	import psc_pkg::*;
	localparam int HOLD = 4; // each pin level stands four core clocks

	////////////////////////////////////////////////////////////////////////////
	// idle bus: serial clock still, enable low
	initial o_bus = '0;

	// let n core clocks pass
	task automatic pause(input int n);
		repeat (n) @(posedge i_clk);
	endtask

	// raise enable to open a frame
	task automatic frame_open();
		@(posedge i_clk);
		o_bus.sen <= 1'b1;
		pause(HOLD);
	endtask

	// one bit, data set before the rising serial clock
	task automatic put_bit(input logic b);
		o_bus.sdata <= b;
		pause(HOLD);
		o_bus.sclk <= 1'b1;
		pause(HOLD);
		o_bus.sclk <= 1'b0;
		pause(HOLD);
	endtask

	// close the frame; the released data line shows the inverse of its last level
	task automatic frame_close();
		o_bus.sen <= 1'b0;
		o_bus.sdata <= ~o_bus.sdata;
		pause(HOLD);
	endtask

	// a whole word, address first, most significant bit first
	task automatic send_word(input logic [7:0] w);
		frame_open();
		for (int i = 7; i >= 0; i--)
			put_bit(w[i]);
		frame_close();
	endtask
endmodule

// >>> verification/testbench.sv
// testbench: self-checking bench of the synthesizer serial control block
`timescale 1ns/100ps
module testbench;
	import psc_pkg::*;
	logic          clk;
	logic          rst_n;
	logic          osc_ref;
	logic          ext_ref;
	logic          fsyn;
	logic          test_in;
	psc_bus_type   bus;
	psc_pump_type  pump;
	logic          filt;
	logic          tout;
	logic          toe;
	logic          oxr;
	psc_mode_type  mode;
	logic [7:0]    pc;
	logic [5:0]    swl;
	logic          step;
	logic [5:0]    t_s;
	logic [5:0]    c_s;
	logic [5:0]    l_s;
	logic [5:0]    s_s;
	logic [7:0]    pc_s;
	int            error_cnt = 0;
	int            cmp_count = 0;

	////////////////////////////////////////////////////////////////////////////
	// design and host model
	psc_serial_ctrl u_dut
	(
		.i_ref_clk            (clk),
		.i_rst_n              (rst_n),
		.i_bus                (bus),
		.i_osc_ref            (osc_ref),
		.i_ext_ref            (ext_ref),
		.i_fsyn               (fsyn),
		.i_test_in            (test_in),
		.o_pump               (pump),
		.o_filter_input_sel   (filt),
		.o_test_out           (tout),
		.o_test_oe            (toe),
		.o_osc_ext_ref        (oxr),
		.o_mode               (mode),
		.o_prog_counter_bits  (pc),
		.o_swallow_count_bits (swl),
		.o_ref_step_sel       (step)
	);

	psc_host_model u_host
	(
		.i_clk (clk),
		.o_bus (bus)
	);

	// 250 MHz core clock
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	////////////////////////////////////////////////////////////////////////////
	// compare and count
	task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
		cmp_count++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// verdict and end of run
	task automatic results();
		$display("compares %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// drive the clock inputs at an edge and let them pass the synchronisers
	task automatic drv(input logic r, input logic e, input logic s, input logic t);
		@(posedge clk);
		osc_ref <= r;
		ext_ref <= e;
		fsyn <= s;
		test_in <= t;
		repeat (6) @(posedge clk);
	endtask

	// send one word and track the expected register contents
	task automatic wr(input logic [1:0] adr, input logic [5:0] d);
		u_host.send_word({adr, d});
		case (adr)
			ADR_TEST: t_s = d;
			ADR_CTRL: c_s = d;
			ADR_LOW:  l_s = d;
			default:
			begin
				s_s = d;
				pc_s = {c_s[PCHI_MSB:PCHI_LSB], l_s};
			end
		endcase
		repeat (6) @(posedge clk);
	endtask

	// filter, current, mode, counter, swallow and step outputs against the expected contents
	task automatic check_regs();
		chk("filter", {7'h00, c_s[FILT_BIT]}, {7'h00, filt});
		chk("current", {6'h00, t_s[CUR2_BIT], c_s[CUR1_BIT]}, {6'h00, pump.cur});
		chk("mode", {6'h00, c_s[BAND_BIT], c_s[SWD_BIT]}, {6'h00, mode});
		chk("counter", pc_s, pc);
		chk("swallow", {2'h0, s_s}, {2'h0, swl});
		chk("step", {7'h00, t_s[STEP_BIT]}, {7'h00, step});
	endtask

	////////////////////////////////////////////////////////////////////////////
	// reset: everything cleared, standby, test pin driven low
	task automatic t_reset();
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		{t_s, c_s, l_s, s_s, pc_s} = '0;
		check_regs();
		chk("tout", 8'h00, {7'h00, tout});
		chk("toe", 8'h01, {7'h00, toe});
		chk("pump", 8'h00, {6'h00, pump.up, pump.dn});
	endtask

	// field layout and delayed counter load
	task automatic t_fields();
		wr(ADR_CTRL, 6'h2d);
		check_regs();
		wr(ADR_LOW, 6'h15);
		check_regs();
		wr(ADR_SWL, 6'h2a);
		check_regs();
		chk("counter", 8'h95, pc);
		wr(ADR_TEST, 6'h07);
		check_regs();
		chk("switch", 8'h03, {6'h00, toe, tout});
		wr(ADR_SWL, 6'h13);
		check_regs();
	endtask

	// the four mode codes
	task automatic t_modes();
		for (int m = 0; m < 4; m++)
		begin
			wr(ADR_CTRL, {4'h6, m[0], m[1]});
			check_regs();
		end
	endtask

	// short and long frames are dropped
	task automatic t_bad();
		u_host.frame_open();
		repeat (7) u_host.put_bit(1'b1);
		u_host.frame_close();
		repeat (6) @(posedge clk);
		check_regs();
		u_host.frame_open();
		repeat (9) u_host.put_bit(1'b1);
		u_host.frame_close();
		repeat (6) @(posedge clk);
		check_regs();
	endtask

	// lead, lag and coincidence on the comparator
	task automatic t_phase();
		wr(ADR_TEST, 6'h00);
		wr(ADR_CTRL, 6'h02);
		drv(1'b1, 1'b0, 1'b0, 1'b0);
		chk("lead", 8'h02, {6'h00, pump.up, pump.dn});
		drv(1'b1, 1'b0, 1'b1, 1'b0);
		chk("lead end", 8'h00, {6'h00, pump.up, pump.dn});
		drv(1'b0, 1'b0, 1'b0, 1'b0);
		drv(1'b0, 1'b0, 1'b1, 1'b0);
		chk("lag", 8'h01, {6'h00, pump.up, pump.dn});
		drv(1'b1, 1'b0, 1'b1, 1'b0);
		chk("lag end", 8'h00, {6'h00, pump.up, pump.dn});
		drv(1'b0, 1'b0, 1'b0, 1'b0);
		drv(1'b1, 1'b0, 1'b1, 1'b0);
		chk("same", 8'h00, {6'h00, pump.up, pump.dn});
		drv(1'b0, 1'b0, 1'b0, 1'b0);
	endtask

	// test codes routing signals to the test and oscillator pins
	task automatic t_test();
		wr(ADR_TEST, 6'h10);
		chk("phi pins", 8'h03, {6'h00, toe, oxr});
		drv(1'b0, 1'b1, 1'b0, 1'b0);
		chk("phi out", 8'h01, {7'h00, tout});
		drv(1'b0, 1'b1, 1'b1, 1'b0);
		chk("phi out", 8'h00, {7'h00, tout});
		wr(ADR_TEST, 6'h30);
		drv(1'b0, 1'b0, 1'b0, 1'b0);
		chk("syn out", 8'h01, {7'h00, oxr});
		chk("syn out", 8'h00, {7'h00, tout});
		drv(1'b0, 1'b0, 1'b1, 1'b0);
		chk("syn out", 8'h01, {7'h00, tout});
		wr(ADR_TEST, 6'h20);
		drv(1'b1, 1'b0, 1'b0, 1'b0);
		chk("ref out", 8'h03, {6'h00, toe, tout});
		drv(1'b0, 1'b0, 1'b0, 1'b0);
		chk("ref out", 8'h00, {6'h00, oxr, tout});
		wr(ADR_TEST, 6'h08);
		chk("phi in", 8'h00, {6'h00, toe, oxr});
		drv(1'b0, 1'b0, 1'b0, 1'b1);
		chk("phi in", 8'h02, {6'h00, pump.up, pump.dn});
		drv(1'b0, 1'b0, 1'b0, 1'b0);
		chk("phi in", 8'h01, {6'h00, pump.up, pump.dn});
		wr(ADR_TEST, 6'h3c);
		chk("code 111", 8'h03, {6'h00, toe, tout});
		chk("code 111", 8'h00, {7'h00, oxr});
		wr(ADR_TEST, 6'h00);
		wr(ADR_CTRL, 6'h00);
		drv(1'b1, 1'b0, 1'b0, 1'b0);
		chk("standby", 8'h00, {6'h00, pump.up, pump.dn});
	endtask

	////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial
	begin
		rst_n = 1'b0;
		osc_ref = 1'b0;
		ext_ref = 1'b0;
		fsyn = 1'b0;
		test_in = 1'b0;
		t_reset();
		t_fields();
		t_modes();
		t_bad();
		t_phase();
		t_test();
		t_reset();
		results();
	end

	// watchdog against a hang
	initial
	begin
		repeat (50000) @(posedge clk);
		error_cnt++;
		results();
	end
endmodule
